// File: logic/pbsp_pkg.sv
// Constants shared by the programmable bus strobe pin block.
// Assumes sys_clk is the double-frequency clock, so one bus cycle is two sys_clk cycles.
// How it works
// RULE_01 - Control register mode bits pick, per dual-role pin, condition input or strobe output.
// RULE_02 - In condition mode the pin level feeds the matching coprocessor condition flag.
// RULE_03 - Each condition input passes through a two-flop synchroniser before it is used.
// RULE_04 - The peripheral strobe asserts on enabled reads or writes from the second bus cycle.
// RULE_05 - The late-release data enable asserts on enabled types and holds half a bus cycle past the strobe.
// RULE_06 - The memory access pulse goes low once per datum of each enabled transfer type.
// RULE_07 - Strobes stay high on disabled types and a pin in condition mode is never driven.
package pbsp_pkg;

  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned AXI_DATA_W = 32;

  // Register byte addresses.
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS_ADDR = 4'h4;

  // Control register field positions.
  localparam int unsigned CTRL_PIN3_STROBE_BIT = 0;
  localparam int unsigned CTRL_PIN2_STROBE_BIT = 1;
  localparam int unsigned CTRL_PER_RD_BIT      = 2;
  localparam int unsigned CTRL_PER_WR_BIT      = 3;
  localparam int unsigned CTRL_LATE_RD_BIT     = 4;
  localparam int unsigned CTRL_LATE_WR_BIT     = 5;
  localparam int unsigned CTRL_MEM_RD_BIT      = 6;
  localparam int unsigned CTRL_MEM_WR_BIT      = 7;
  localparam int unsigned CTRL_W               = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET     = 8'h00;

  // Status register field positions.
  localparam int unsigned STAT_COND2_BIT = 0;
  localparam int unsigned STAT_COND3_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT  = 2;
  localparam int unsigned STAT_PER_BIT   = 3;
  localparam int unsigned STAT_LATE_BIT  = 4;
  localparam int unsigned STAT_MEM_BIT   = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing in the bus clock, expressed in sys_clk cycles.
  localparam int unsigned SYS_CLK_MHZ     = 200;
  localparam int unsigned BUS_CYCLE_NS    = 10;
  localparam int unsigned HALF_BUS_NS     = 5;
  localparam int unsigned STROBE_START_CLKS =
    (BUS_CYCLE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned LATE_HOLD_CLKS =
    ((HALF_BUS_NS * SYS_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (HALF_BUS_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 4;

  typedef enum logic [2:0] {
    PBSP_IDLE = 3'b001,
    PBSP_DATA = 3'b010,
    PBSP_RESP = 3'b100
  } pbsp_axi_st_t;

endpackage

// File: logic/pbsp_sync.sv
// Multi-stage level synchroniser for asynchronous condition inputs.
// Assumes the destination clock is sys_clk; the enable freezes every stage.
`timescale 1ns/1ps
`default_nettype none
module pbsp_sync #(
  parameter int unsigned WIDTH  = 2,
  parameter int unsigned STAGES = 2
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              clkEn,
  input  wire logic [WIDTH-1:0]  asyncIn,
  output logic      [WIDTH-1:0]  syncOut
);

  logic [WIDTH-1:0] stage_ff     [STAGES];
  logic [WIDTH-1:0] nxt_stage    [STAGES];

  // A single stage gives no settling time, so such a build is refused.
  if (STAGES < 2) begin : gBadStages
    $error("pbsp_sync needs at least two stages");
  end

  // Only the last stage is visible outside; earlier stages feed the next one alone.
  always_comb begin
    nxt_stage[0] = clkEn ? asyncIn : stage_ff[0];
    for (int i = 1; i < STAGES; i++) begin
      nxt_stage[i] = clkEn ? stage_ff[i-1] : stage_ff[i];
    end
  end

  generate
    for (genvar g = 0; g < STAGES; g++) begin : gStage
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          stage_ff[g] <= '0;
        end else begin
          stage_ff[g] <= nxt_stage[g];
        end
      end
    end
  endgenerate

  assign syncOut = stage_ff[STAGES-1];

endmodule
`default_nettype wire

// File: logic/pbsp_strobes.sv
// Dual-role condition/strobe pins and memory access pulse with an AXI4-Lite control port.
// Assumes the bus unit gives read and write levels and a one-cycle pulse per datum.
`timescale 1ns/1ps
`default_nettype none
module pbsp_strobes #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  input  wire logic                             clkEn,
  // AXI4-Lite slave.
  input  wire logic [pbsp_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [pbsp_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [pbsp_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [pbsp_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Bus unit transfer state.
  input  wire logic                             xferRd,
  input  wire logic                             xferWr,
  input  wire logic                             datumDone,
  // Dual-role pin 3: condition input or peripheral strobe.
  input  wire logic                             condPin3I,
  output logic                                  condPin3O,
  output logic                                  condPin3Oe,
  // Dual-role pin 2: condition input or late-release data enable.
  input  wire logic                             condPin2I,
  output logic                                  condPin2O,
  output logic                                  condPin2Oe,
  output logic                                  memoryAccessPulse_n,
  // Condition flags to the system control coprocessor.
  output logic                                  cpCondFlag3,
  output logic                                  cpCondFlag2
);
  import pbsp_pkg::*;

  // Fewer than two stages cannot make the condition inputs safe.
  if (SYNC_STAGES < 2) begin : gBadStages
    $error("SYNC_STAGES must be at least two");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave.

  logic [CTRL_W-1:0]     ctrl_ff,    nxt_ctrl;
  logic                  awHave_ff,  nxt_awHave;
  logic                  wHave_ff,   nxt_wHave;
  logic [AXI_ADDR_W-1:0] awAddr_ff,  nxt_awAddr;
  logic [7:0]            wByte_ff,   nxt_wByte;
  logic                  wStrb0_ff,  nxt_wStrb0;
  logic                  bValid_ff,  nxt_bValid;
  logic [1:0]            bResp_ff,   nxt_bResp;
  logic                  rValid_ff,  nxt_rValid;
  logic [1:0]            rResp_ff,   nxt_rResp;
  logic [AXI_DATA_W-1:0] rData_ff,   nxt_rData;
  logic [AXI_DATA_W-1:0] statusWord;
  logic [1:0]            condSync;
  logic                  perAct_ff,  lateAct_ff,  memAct_ff;

  assign s_axi_awready = clkEn && !awHave_ff && !bValid_ff;
  assign s_axi_wready  = clkEn && !wHave_ff && !bValid_ff;
  assign s_axi_arready = clkEn && !rValid_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rresp   = rResp_ff;
  assign s_axi_rdata   = rData_ff;

  always_comb begin
    statusWord                 = '0;
    statusWord[STAT_COND2_BIT] = condSync[0];
    statusWord[STAT_COND3_BIT] = condSync[1];
    statusWord[STAT_BUSY_BIT]  = xferRd || xferWr;
    statusWord[STAT_PER_BIT]   = perAct_ff;
    statusWord[STAT_LATE_BIT]  = lateAct_ff;
    statusWord[STAT_MEM_BIT]   = memAct_ff;
  end

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_awHave = awHave_ff;
    nxt_wHave  = wHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wByte  = wByte_ff;
    nxt_wStrb0 = wStrb0_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp  = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rResp  = rResp_ff;
    nxt_rData  = rData_ff;
    if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        nxt_awHave = 1'b1;
        nxt_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        nxt_wHave  = 1'b1;
        nxt_wByte  = s_axi_wdata[7:0];
        nxt_wStrb0 = s_axi_wstrb[0];
      end
      // Both halves held: perform the write and answer one cycle later.
      if (awHave_ff && wHave_ff) begin
        nxt_awHave = 1'b0;
        nxt_wHave  = 1'b0;
        nxt_bValid = 1'b1;
        if (awAddr_ff == REG_CTRL_ADDR) begin
          nxt_bResp = RESP_OKAY;
          if (wStrb0_ff) begin
            nxt_ctrl = wByte_ff;
          end
        end else if (awAddr_ff == REG_STATUS_ADDR) begin
          nxt_bResp = RESP_OKAY;
        end else begin
          nxt_bResp = RESP_SLVERR;
        end
      end
      if (bValid_ff && s_axi_bready) begin
        nxt_bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        nxt_rValid = 1'b1;
        nxt_rResp  = RESP_OKAY;
        unique case (s_axi_araddr)
          REG_CTRL_ADDR:   nxt_rData = {{(AXI_DATA_W-CTRL_W){1'b0}}, ctrl_ff};
          REG_STATUS_ADDR: nxt_rData = statusWord;
          default: begin
            nxt_rData = '0;
            nxt_rResp = RESP_SLVERR;
          end
        endcase
      end else if (rValid_ff && s_axi_rready) begin
        nxt_rValid = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff   <= CTRL_RESET;
      awHave_ff <= 1'b0;
      wHave_ff  <= 1'b0;
      awAddr_ff <= '0;
      wByte_ff  <= '0;
      wStrb0_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rResp_ff  <= RESP_OKAY;
      rData_ff  <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      awHave_ff <= nxt_awHave;
      wHave_ff  <= nxt_wHave;
      awAddr_ff <= nxt_awAddr;
      wByte_ff  <= nxt_wByte;
      wStrb0_ff <= nxt_wStrb0;
      bValid_ff <= nxt_bValid;
      bResp_ff  <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rResp_ff  <= nxt_rResp;
      rData_ff  <= nxt_rData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition inputs.

  logic pin3Strobe;
  logic pin2Strobe;

  // RULE_01 - pin role select
  assign pin3Strobe = ctrl_ff[CTRL_PIN3_STROBE_BIT];
  assign pin2Strobe = ctrl_ff[CTRL_PIN2_STROBE_BIT];

  // RULE_03 - synchronise condition inputs
  pbsp_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) uSync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .asyncIn ({condPin3I, condPin2I}),
    .syncOut (condSync)
  );

  // RULE_02 - feed coprocessor flags
  assign cpCondFlag3 = !pin3Strobe && condSync[1];
  assign cpCondFlag2 = !pin2Strobe && condSync[0];

  //////////////////////////////////////////////////////////////////////////////
  // Strobe generation.

  logic             xferAct;
  logic [CNT_W-1:0] xferCnt_ff,  nxt_xferCnt;
  logic [CNT_W-1:0] holdCnt_ff,  nxt_holdCnt;
  logic             lastRd_ff,   nxt_lastRd;
  logic             nxt_perAct,  nxt_lateAct, nxt_memAct;
  logic             perEn,       lateEn,      lateHoldEn,  memEn;

  assign xferAct = xferRd || xferWr;

  // RULE_07 - only enabled types assert
  assign perEn      = (xferRd && ctrl_ff[CTRL_PER_RD_BIT]) || (xferWr && ctrl_ff[CTRL_PER_WR_BIT]);
  assign lateEn     = (xferRd && ctrl_ff[CTRL_LATE_RD_BIT]) ||
                      (xferWr && ctrl_ff[CTRL_LATE_WR_BIT]);
  assign lateHoldEn = lastRd_ff ? ctrl_ff[CTRL_LATE_RD_BIT] : ctrl_ff[CTRL_LATE_WR_BIT];
  assign memEn      = (xferRd && ctrl_ff[CTRL_MEM_RD_BIT]) || (xferWr && ctrl_ff[CTRL_MEM_WR_BIT]);

  always_comb begin
    nxt_xferCnt = xferCnt_ff;
    nxt_holdCnt = holdCnt_ff;
    nxt_lastRd  = lastRd_ff;
    nxt_perAct  = perAct_ff;
    nxt_lateAct = lateAct_ff;
    nxt_memAct  = memAct_ff;
    if (clkEn) begin
      if (xferAct) begin
        nxt_lastRd = xferRd;
        if (xferCnt_ff != {CNT_W{1'b1}}) begin
          nxt_xferCnt = xferCnt_ff + 1'b1;
        end
        nxt_holdCnt = CNT_W'(LATE_HOLD_CLKS);
      end else begin
        nxt_xferCnt = '0;
        if (holdCnt_ff != '0) begin
          nxt_holdCnt = holdCnt_ff - 1'b1;
        end
      end
      // RULE_04 - start in second bus cycle
      nxt_perAct  = perEn && (xferCnt_ff >= CNT_W'(STROBE_START_CLKS - 1));
      // RULE_05 - hold past strobe negation
      nxt_lateAct = lateEn || (!xferAct && holdCnt_ff != '0 && lateHoldEn);
      // RULE_06 - one low pulse per datum
      nxt_memAct  = datumDone && memEn;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      xferCnt_ff <= '0;
      holdCnt_ff <= '0;
      lastRd_ff  <= 1'b0;
      perAct_ff  <= 1'b0;
      lateAct_ff <= 1'b0;
      memAct_ff  <= 1'b0;
    end else begin
      xferCnt_ff <= nxt_xferCnt;
      holdCnt_ff <= nxt_holdCnt;
      lastRd_ff  <= nxt_lastRd;
      perAct_ff  <= nxt_perAct;
      lateAct_ff <= nxt_lateAct;
      memAct_ff  <= nxt_memAct;
    end
  end

  // RULE_07 - release pins in condition mode
  assign condPin3Oe          = pin3Strobe;
  assign condPin3O           = !(pin3Strobe && perAct_ff);
  assign condPin2Oe          = pin2Strobe;
  assign condPin2O           = !(pin2Strobe && lateAct_ff);
  assign memoryAccessPulse_n = !memAct_ff;

endmodule
`default_nettype wire

// File: testbench/pbsp_strobes_chk.sv
// Port-level assertions for the strobe pin block.
// Assumes binding into pbsp_strobes and transfers spaced by idle cycles.
`timescale 1ns/1ps
`default_nettype none
module pbsp_strobes_chk #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic xferRd,
  input wire logic xferWr,
  input wire logic datumDone,
  input wire logic condPin3I,
  input wire logic condPin3O,
  input wire logic condPin3Oe,
  input wire logic condPin2I,
  input wire logic condPin2O,
  input wire logic condPin2Oe,
  input wire logic memoryAccessPulse_n,
  input wire logic cpCondFlag3,
  input wire logic cpCondFlag2
);
  logic       anyX;
  logic [3:0] liveCnt;
  assign anyX = xferRd | xferWr;
  // Edges since reset release; the synchroniser shows reset values until it has refilled.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) liveCnt <= 4'h0;
    else if (liveCnt != 4'hf) liveCnt <= liveCnt + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_pin3Idle; !condPin3Oe |-> condPin3O; endproperty
  a_pin3Idle: assert property (p_pin3Idle) else $error("pin3 low");
  property p_pin2Idle; !condPin2Oe |-> condPin2O; endproperty
  a_pin2Idle: assert property (p_pin2Idle) else $error("pin2 low");
  property p_sync3;
    (!condPin3Oe && clkEn)[*3] ##0 (liveCnt >= SYNC_STAGES) |->
      cpCondFlag3 == $past(condPin3I, SYNC_STAGES);
  endproperty
  a_sync3: assert property (p_sync3) else $error("flag3 wrong");
  property p_sync2;
    (!condPin2Oe && clkEn)[*3] ##0 (liveCnt >= SYNC_STAGES) |->
      cpCondFlag2 == $past(condPin2I, SYNC_STAGES);
  endproperty
  a_sync2: assert property (p_sync2) else $error("flag2 wrong");
  property p_perStart; $fell(condPin3O) |-> $past(anyX, 1) && $past(anyX, 2); endproperty
  a_perStart: assert property (p_perStart) else $error("strobe early");
  property p_perEnd; $fell(anyX) && !condPin3O |=> condPin3O; endproperty
  a_perEnd: assert property (p_perEnd) else $error("strobe late");
  property p_lateHold; $fell(anyX) && !condPin2O |-> ##1 !condPin2O ##1 condPin2O; endproperty
  a_lateHold: assert property (p_lateHold) else $error("hold wrong");
  property p_memPulse; !memoryAccessPulse_n |-> $past(datumDone) && $past(anyX); endproperty
  a_memPulse: assert property (p_memPulse) else $error("stray pulse");
endmodule
bind pbsp_strobes pbsp_strobes_chk #(.SYNC_STAGES(SYNC_STAGES)) pbsp_strobes_chk_i (.*);
`default_nettype wire

// File: testbench/pbsp_far_side.sv
// Far side of the pins: an unclocked agent on the condition pins and a counter of memory access pulses.
// Assumes the agent lets go of a pin while the block drives it.
`timescale 1ns/1ps
`default_nettype none
module pbsp_far_side (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pinO3,
  input wire logic pinOe3,
  input wire logic pinO2,
  input wire logic pinOe2,
  input wire logic accessPulse_n,
  input wire logic agent3,
  input wire logic agent2,
  output logic     pinLvl3,
  output logic     pinLvl2,
  output int       pulses
);
  logic lvl3 = 1'b1;
  logic lvl2 = 1'b1;
  always @(agent3, agent2) begin
    lvl3 <= #2 agent3;
    lvl2 <= #2 agent2;
  end
  assign pinLvl3 = pinOe3 ? pinO3 : lvl3;
  assign pinLvl2 = pinOe2 ? pinO2 : lvl2;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) pulses <= 0;
    else if (!accessPulse_n) pulses <= pulses + 1;
  end
endmodule
`default_nettype wire

// File: testbench/tb_pbsp_strobes.sv
// Self-checking bench for pbsp_strobes with an AXI4-Lite master.
// Assumes the far-side model feeds the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_pbsp_strobes;
  import pbsp_pkg::*;
  logic sys_clk, arst_n, clkEn, xferRd, xferWr, datumDone, agent3, agent2;
  logic condPin3I, condPin3O, condPin3Oe, condPin2I, condPin2O, condPin2Oe;
  logic memoryAccessPulse_n, cpCondFlag3, cpCondFlag2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, d;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, r;
  logic [7:0]            ctrl;
  int                    seed = 84392;
  int                    miscompares = 0;
  int                    cmp_count = 0;
  int                    pulses;
  pbsp_strobes #(.SYNC_STAGES(2)) pbsp_strobes_i (.*);
  pbsp_far_side pbsp_far_side_i (.sys_clk, .arst_n, .pinO3(condPin3O), .pinOe3(condPin3Oe),
    .pinO2(condPin2O), .pinOe2(condPin2Oe), .accessPulse_n(memoryAccessPulse_n),
    .agent3, .agent2, .pinLvl3(condPin3I), .pinLvl2(condPin2I), .pulses);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chkb(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] st);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (aw && s_axi_awready === 1'b1) aw = 1'b0;
      if (w && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (w && s_axi_wready === 1'b1) w = 1'b0;
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic axr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One transfer of n cycles with random datum pulses, checked every cycle.
  task automatic xfer(input logic rd, input int n);
    logic pe, le, me, dd, pdd;
    int p0, np;
    pe = ctrl[0] && ctrl[rd ? 2 : 3];
    le = ctrl[1] && ctrl[rd ? 4 : 5];
    me = ctrl[rd ? 6 : 7];
    pdd = 1'b0;
    p0 = pulses;
    np = 0;
    for (int j = 0; j <= n + 2; j++) begin
      dd = (j > 0) && (j < n) && 1'($random(seed));
      xferRd <= rd && (j < n);
      xferWr <= !rd && (j < n);
      datumDone <= dd;
      @(posedge sys_clk);
      chkb("per", !(pe && j >= 2 && j <= n), condPin3O);
      chkb("late", !(le && j >= 1 && j <= n + 1), condPin2O);
      chkb("mem", !(me && pdd), memoryAccessPulse_n);
      if (me && pdd) np++;
      pdd = dd;
    end
    chkw("count", np, pulses - p0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_clk, arst_n, xferRd, xferWr, datumDone, agent3, agent2} = 7'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 44'h0;
    clkEn = 1'b1;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chkb("oe3", 1'b0, condPin3Oe);
    chkb("oe2", 1'b0, condPin2Oe);
    chkb("mem", 1'b1, memoryAccessPulse_n);
    axw(REG_CTRL_ADDR, 32'hff, 4'h0);
    chkw("bresp", 32'(RESP_OKAY), 32'(r));
    axw(4'hc, 32'hff, 4'hf);
    chkw("bresp", 32'(RESP_SLVERR), 32'(r));
    axr(REG_CTRL_ADDR);
    chkw("ctrl", 32'(CTRL_RESET), d);
    axr(4'h8);
    chkw("resp", 32'(RESP_SLVERR), 32'(r));
    clkEn <= 1'b0;
    @(posedge sys_clk);
    chkb("arready", 1'b0, s_axi_arready);
    clkEn <= 1'b1;
    $display("test registers done");
    repeat (20) begin
      agent3 <= 1'($random(seed));
      agent2 <= 1'($random(seed));
      @(posedge sys_clk);
    end
    for (int i = 0; i < 4; i++) begin
      agent3 <= i[1];
      agent2 <= i[0];
      repeat (4) @(posedge sys_clk);
      chkb("flag3", i[1], cpCondFlag3);
      chkb("flag2", i[0], cpCondFlag2);
      axr(REG_STATUS_ADDR);
      chkw("status", 32'({i[1], i[0]}), d);
    end
    $display("test condition done");
    for (int k = 0; k < 10; k++) begin
      ctrl = (k < 8) ? {~k[2], k[2], ~k[1], k[1], ~k[0], k[0], 2'b11} : {6'h3f, k[0], ~k[0]};
      axw(REG_CTRL_ADDR, 32'(ctrl), 4'h1);
      axr(REG_CTRL_ADDR);
      chkw("ctrl", 32'(ctrl), d);
      chkb("oe3", ctrl[0], condPin3Oe);
      chkb("oe2", ctrl[1], condPin2Oe);
      chkb("flag3", !ctrl[0], cpCondFlag3);
      chkb("flag2", !ctrl[1], cpCondFlag2);
      xfer(1'b1, 2 + int'({$random(seed)} % 4));
      xfer(1'b0, 2 + int'({$random(seed)} % 4));
      $display("test strobes %0d done", k);
    end
    give_verdict();
  end
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
